// file: hw/rso_regs.vh
// Purpose: constants of the reading store and output unit
// Assumes: apb byte offsets, 200 MHz clock
// Notes: times are in ns, cycle counts are derived from them
`ifndef RSO_REGS_VH
`define RSO_REGS_VH

// register byte offsets
`define RSO_OFF_BASE 8'h00
`define RSO_OFF_SIZE 8'h04
`define RSO_OFF_STORE 8'h08
`define RSO_OFF_ROUTE 8'h0c
`define RSO_OFF_NEXT 8'h10
`define RSO_OFF_STAT 8'h14
`define RSO_OFF_CTRL 8'h18
`define RSO_OFF_BMIN 8'h1c
`define RSO_OFF_BMAX 8'h20
`define RSO_OFF_COUNT 8'h24

// window limits and reset values
`define RSO_BASE_RST 24'h200000
`define RSO_BASE_MIN 24'h200000
`define RSO_BASE_MAX 24'hdffffc
`define RSO_SIZE_RST 25'h0000000
`define RSO_SIZE_MAX 25'h0c00000
`define RSO_SUM_MAX 25'h0e00000
`define RSO_WORD_BYTES 25'h0000004

// status bit positions
`define RSO_ST_FULL 0
`define RSO_ST_BUSY 1
`define RSO_ST_EMPTY 2
`define RSO_ST_DIRECT 3
`define RSO_ST_OVER 4

// control bit positions (write one to act)
`define RSO_CT_START 0
`define RSO_CT_STOP 1
`define RSO_CT_REWIND 2

// queue depths
`define RSO_FIFO_WORDS 10'h200
`define RSO_OBUF_BYTES 8'h80

// strobe low times in ns
`define RSO_CLK_NS 32'd5
`define RSO_T_350MS 32'd350000000
`define RSO_T_20M5 32'd20500000
`define RSO_T_17M2 32'd17200000
`define RSO_T_3M1 32'd3100000
`define RSO_T_520US 32'd520000
`define RSO_T_430US 32'd430000
`define RSO_T_390US 32'd390000
`define RSO_T_370US 32'd370000
`define RSO_T_350US 32'd350000
`define RSO_T_250US 32'd250000
`define RSO_T_70US 32'd70000
`define RSO_CYC(t) (((t) + `RSO_CLK_NS - 32'd1) / `RSO_CLK_NS)

`endif

// file: hw/rso_strobe.v
// Purpose: timed active-low completion strobe
// Assumes: fire is a one-cycle pulse, len is at least one
// Notes: a fire during a running strobe restarts it
`timescale 1ns/1ps
module rso_strobe (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // control
  input wire fire,
  input wire [31:0] len,
  // strobe
  output reg strobe_n
);

reg [31:0] cnt_q;

always @(posedge clock or posedge sys_rst) begin
  if (sys_rst) begin
    cnt_q <= 32'h00000000;
    strobe_n <= 1'b1;
  end else if (fire) begin
    cnt_q <= len;
    strobe_n <= 1'b0;
  end else if (cnt_q > 32'h00000001) begin
    cnt_q <= cnt_q - 32'h00000001;
  end else begin
    cnt_q <= 32'h00000000;
    strobe_n <= 1'b1;
  end
end

endmodule

// file: hw/rso_top.v
// Purpose: reading store and output unit with apb registers
// Assumes: readings arrive as ieee-754 single words, inputs synchronous
`timescale 1ns/1ps
`include "rso_regs.vh"
module rso_top #(
  // strobe cycles, entries 0-7 autozero off, 8-15 on, by aperture
  parameter [511:0] STRB_CYC = {
    `RSO_CYC(`RSO_T_70US), `RSO_CYC(`RSO_T_70US),
    `RSO_CYC(`RSO_T_520US), `RSO_CYC(`RSO_T_3M1),
    `RSO_CYC(`RSO_T_17M2), `RSO_CYC(`RSO_T_20M5),
    `RSO_CYC(`RSO_T_370US), `RSO_CYC(`RSO_T_350MS),
    `RSO_CYC(`RSO_T_70US), `RSO_CYC(`RSO_T_70US),
    `RSO_CYC(`RSO_T_250US), `RSO_CYC(`RSO_T_430US),
    `RSO_CYC(`RSO_T_390US), `RSO_CYC(`RSO_T_370US),
    `RSO_CYC(`RSO_T_370US), `RSO_CYC(`RSO_T_350US)}
) (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  // measurement side
  input wire sample_done,
  input wire [2:0] aperture_sel,
  input wire autozero,
  input wire rd_valid,
  input wire [31:0] rd_word,
  input wire rd_short,
  output wire rd_ready,
  output reg meas_arm,
  // external memory writes
  output reg mem_req,
  output reg [23:0] mem_addr,
  output reg [31:0] mem_data,
  input wire mem_ack,
  // host output buffer
  output wire ob_valid,
  output wire [7:0] ob_data,
  output wire ob_eoi,
  input wire ob_ready,
  output wire out_busy,
  // strobes
  output wire reading_done_strobe_n,
  output wire [7:0] backplane_trigger_line_o,
  output wire [7:0] backplane_trigger_line_oe_n
);

localparam FMT_IDLE = 2'b00;
localparam FMT_HEX = 2'b01;
localparam FMT_SEP = 2'b10;
reg [23:0] ext_mem_base_setting_q;
reg [24:0] ext_mem_window_size_q;
reg ext_mem_store_enable_q;
reg [7:0] strobe_route_enable_q;
reg [24:0] used_q;
reg full_q;
reg over_q;
reg direct_q;
reg [31:0] count_q;
reg [31:0] sent_q;
reg [31:0] fifo_data_q [0:511];
reg fifo_short_q [0:511];
reg [8:0] fwp_q;
reg [8:0] frp_q;
reg [9:0] fent_q;
reg [9:0] fwords_q;
reg [7:0] obuf_q [0:127];
reg obuf_eoi_q [0:127];
reg [6:0] owp_q;
reg [6:0] orp_q;
reg [7:0] ocnt_q;
reg [1:0] fmt_q;
reg [2:0] nib_q;
reg [31:0] hold_q;
////////////////////////////////////////////////////////////////////////
// apb decode
wire wr = psel & penable & pwrite;
wire setup = psel & ~penable;
wire [31:0] ctrl_w = (wr && paddr == `RSO_OFF_CTRL) ? pwdata : 32'h0;
wire start = ctrl_w[`RSO_CT_START];
wire stop = ctrl_w[`RSO_CT_STOP];
wire rewind = ctrl_w[`RSO_CT_REWIND] |
  (wr && paddr == `RSO_OFF_STORE && pwdata[0] && !ext_mem_store_enable_q);
wire base_ok = pwdata[31:24] == 8'h00 && pwdata[1:0] == 2'b00 &&
  pwdata[23:0] >= `RSO_BASE_MIN && pwdata[23:0] <= `RSO_BASE_MAX;
wire size_ok = pwdata[31:25] == 7'h00 &&
  pwdata[24:0] <= `RSO_SIZE_MAX;
wire [24:0] span = {1'b0, ext_mem_base_setting_q} + ext_mem_window_size_q;
wire fifo_empty = fent_q == 10'h000;
wire ob_full = ocnt_q == `RSO_OBUF_BYTES;
wire [31:0] status = {27'h0, over_q, direct_q, fifo_empty & ~direct_q,
  ob_full, full_q} | ({31'h0, span > `RSO_SUM_MAX} << `RSO_ST_OVER);
assign pready = 1'b1;

always @(posedge clock or posedge sys_rst) begin
  if (sys_rst) begin
    prdata <= 32'h00000000;
    pslverr <= 1'b0;
  end else if (setup) begin
    pslverr <= 1'b0;
    case (paddr)
      `RSO_OFF_BASE: prdata <= {8'h00, ext_mem_base_setting_q};
      `RSO_OFF_SIZE: prdata <= {7'h00, ext_mem_window_size_q};
      `RSO_OFF_STORE: prdata <= {31'h0, ext_mem_store_enable_q};
      `RSO_OFF_ROUTE: prdata <= {24'h0, strobe_route_enable_q};
      `RSO_OFF_NEXT: prdata <= {8'h00, mem_addr};
      `RSO_OFF_STAT: prdata <= status;
      `RSO_OFF_CTRL: prdata <= 32'h00000000;
      `RSO_OFF_BMIN: prdata <= {8'h00, `RSO_BASE_MIN};
      `RSO_OFF_BMAX: prdata <= {8'h00, `RSO_BASE_MAX};
      `RSO_OFF_COUNT: prdata <= count_q;
      default: begin
        prdata <= 32'h00000000;
        pslverr <= 1'b1;
      end
    endcase
    if (pwrite && paddr == `RSO_OFF_BASE && !base_ok) begin
      pslverr <= 1'b1;
    end
    if (pwrite && paddr == `RSO_OFF_SIZE && !size_ok) begin
      pslverr <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// settings registers, out of range writes are refused
always @(posedge clock or posedge sys_rst) begin
  if (sys_rst) begin
    ext_mem_base_setting_q <= `RSO_BASE_RST;
    ext_mem_window_size_q <= `RSO_SIZE_RST;
    ext_mem_store_enable_q <= 1'b0;
    strobe_route_enable_q <= 8'h00;
    count_q <= 32'h00000000;
  end else if (wr) begin
    case (paddr)
      `RSO_OFF_BASE: if (base_ok) begin
        ext_mem_base_setting_q <= pwdata[23:0];
      end
      `RSO_OFF_SIZE: if (size_ok) begin
        ext_mem_window_size_q <= pwdata[24:0];
      end
      `RSO_OFF_STORE: ext_mem_store_enable_q <= pwdata[0];
      `RSO_OFF_ROUTE: strobe_route_enable_q <= pwdata[7:0];
      `RSO_OFF_COUNT: count_q <= pwdata;
      default: ;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// reading fifo, counted in words
wire [9:0] need = rd_short ? 10'h001 : 10'h002;
assign rd_ready = fwords_q + need <= `RSO_FIFO_WORDS;
wire push = rd_valid & rd_ready;
wire [31:0] head = fifo_data_q[frp_q];
wire [9:0] head_w = fifo_short_q[frp_q] ? 10'h001 : 10'h002;
wire room = used_q + `RSO_WORD_BYTES <= ext_mem_window_size_q;
wire to_fmt = direct_q & (fmt_q == FMT_IDLE);
wire to_mem = ~direct_q & ext_mem_store_enable_q & ~mem_req & room;
wire drop = ~direct_q & ~(ext_mem_store_enable_q & (mem_req | room));
wire pop = ~fifo_empty & (to_fmt | to_mem | drop);
always @(posedge clock) begin
  if (push) begin
    fifo_data_q[fwp_q] <= rd_word;
    fifo_short_q[fwp_q] <= rd_short;
  end
end

always @(posedge clock or posedge sys_rst) begin
  if (sys_rst) begin
    fwp_q <= 9'h000;
    frp_q <= 9'h000;
    fent_q <= 10'h000;
    fwords_q <= 10'h000;
  end else begin
    if (push) begin
      fwp_q <= fwp_q + 9'h001;
    end
    if (pop) begin
      frp_q <= frp_q + 9'h001;
    end
    fent_q <= fent_q + {9'h0, push} - {9'h0, pop};
    fwords_q <= fwords_q + (push ? need : 10'h000) -
      (pop ? head_w : 10'h000);
  end
end

////////////////////////////////////////////////////////////////////////
// external memory writer
always @(posedge clock or posedge sys_rst) begin
  if (sys_rst) begin
    mem_req <= 1'b0;
    mem_addr <= `RSO_BASE_RST;
    mem_data <= 32'h00000000;
    used_q <= 25'h0000000;
    full_q <= 1'b0;
    over_q <= 1'b0;
  end else begin
    if (rewind) begin
      used_q <= 25'h0000000;
      mem_addr <= ext_mem_base_setting_q;
      full_q <= 1'b0;
    end else if (mem_req && mem_ack) begin
      used_q <= used_q + `RSO_WORD_BYTES;
      mem_addr <= mem_addr + 24'h000004;
    end
    if (mem_req && mem_ack) begin
      mem_req <= 1'b0;
    end else if (pop && to_mem) begin
      mem_req <= 1'b1;
      mem_data <= head;
    end
    // set wins over rewind
    if (pop && drop && ext_mem_store_enable_q) begin
      full_q <= 1'b1;
    end
    over_q <= span > `RSO_SUM_MAX;
  end
end

////////////////////////////////////////////////////////////////////////
// text formatter: eight hex digits, then comma or lf
function [7:0] hex_char;
  input [3:0] n;
  begin
    hex_char = (n < 4'ha) ? 8'h30 + {4'h0, n} : 8'h57 + {4'h0, n};
  end
endfunction
// zero count means no limit
wire last = count_q != 32'h0 && sent_q + 32'h1 == count_q;
wire [3:0] cur_nib = hold_q[31:28];
wire ob_we = ~ob_full & (fmt_q == FMT_HEX || fmt_q == FMT_SEP);
wire [7:0] ob_din = (fmt_q == FMT_HEX) ? hex_char(cur_nib) :
  (last ? 8'h0a : 8'h2c);
wire ob_eoi_in = fmt_q == FMT_SEP && last;

always @(posedge clock or posedge sys_rst) begin
  if (sys_rst) begin
    fmt_q <= FMT_IDLE;
    nib_q <= 3'h0;
    hold_q <= 32'h00000000;
    sent_q <= 32'h00000000;
  end else begin
    case (fmt_q)
      FMT_IDLE: begin
        if (start) begin
          sent_q <= 32'h00000000;
        end
        if (pop && to_fmt) begin
          hold_q <= head;
          nib_q <= 3'h0;
          fmt_q <= FMT_HEX;
        end
      end
      FMT_HEX: if (ob_we) begin
        hold_q <= {hold_q[27:0], 4'h0};
        nib_q <= nib_q + 3'h1;
        if (nib_q == 3'h7) begin
          fmt_q <= FMT_SEP;
        end
      end
      FMT_SEP: if (ob_we) begin
        sent_q <= sent_q + 32'h1;
        fmt_q <= FMT_IDLE;
      end
      default: fmt_q <= FMT_IDLE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////
// direct mode control
always @(posedge clock or posedge sys_rst) begin
  if (sys_rst) begin
    direct_q <= 1'b0;
    meas_arm <= 1'b0;
  end else begin
    meas_arm <= start;
    if (start) begin
      direct_q <= 1'b1;
    end else if (stop || (ob_we && ob_eoi_in)) begin
      direct_q <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// 128 byte host output buffer
wire ob_rd = ob_valid & ob_ready;
assign ob_valid = ocnt_q != 8'h00;
assign ob_data = obuf_q[orp_q];
assign ob_eoi = obuf_eoi_q[orp_q];
assign out_busy = ob_full;

always @(posedge clock) begin
  if (ob_we) begin
    obuf_q[owp_q] <= ob_din;
    obuf_eoi_q[owp_q] <= ob_eoi_in;
  end
end

always @(posedge clock or posedge sys_rst) begin
  if (sys_rst) begin
    owp_q <= 7'h00;
    orp_q <= 7'h00;
    ocnt_q <= 8'h00;
  end else begin
    if (ob_we) begin
      owp_q <= owp_q + 7'h01;
    end
    if (ob_rd) begin
      orp_q <= orp_q + 7'h01;
    end
    ocnt_q <= ocnt_q + {7'h0, ob_we} - {7'h0, ob_rd};
  end
end

////////////////////////////////////////////////////////////////////////
// completion strobe and backplane routing
wire [3:0] strb_idx = {autozero, aperture_sel};
wire [31:0] strb_len = STRB_CYC[strb_idx * 32 +: 32];
rso_strobe u_strobe (
  .clock(clock),
  .sys_rst(sys_rst),
  .fire(sample_done),
  .len(strb_len),
  .strobe_n(reading_done_strobe_n)
);
genvar gi;
generate
  for (gi = 0; gi < 8; gi = gi + 1) begin : g_line
    // pull low only while routed and strobe active
    assign backplane_trigger_line_o[gi] = 1'b0;
    assign backplane_trigger_line_oe_n[gi] =
      ~(strobe_route_enable_q[gi] & ~reading_done_strobe_n);
  end
endgenerate

endmodule

// file: sim/rso_far.sv
// Purpose: memory card and host model for rso_top
// Assumes: one memory write outstanding at a time
// Notes: logs stored words and received bytes in queues
`timescale 1ns/1ps
module rso_far (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // memory card side
  input wire mem_req,
  input wire [23:0] mem_addr,
  input wire [31:0] mem_data,
  output logic mem_ack,
  // host side
  input wire ob_valid,
  input wire [7:0] ob_data,
  input wire ob_eoi,
  output logic ob_ready,
  // behaviour
  input wire [3:0] ack_dly,
  input wire stall
);
  logic [3:0] wait_q;
  logic [23:0] wa[$];
  logic [31:0] wd[$];
  logic [8:0] ob_q[$];
  ////////////////////////////////////////////////////////////
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      wait_q <= 4'h0;
      ob_ready <= 1'b0;
    end else begin
      // host drains every cycle unless told to stall
      ob_ready <= !stall;
      if (ob_valid && ob_ready)
        ob_q.push_back({ob_eoi, ob_data});
      if (mem_req && mem_ack) begin
        wa.push_back(mem_addr);
        wd.push_back(mem_data);
        mem_ack <= 1'b0;
        wait_q <= 4'h0;
      end else if (mem_req) begin
        wait_q <= wait_q + 4'h1;
        mem_ack <= (wait_q >= ack_dly);
      end
    end
  end
endmodule

// file: sim/rso_top_assertions.sv
// Purpose: port checker for rso_top
// Assumes: every strobe table entry holds the same length
// Notes: bound to each rso_top instance
`timescale 1ns/1ps
`include "rso_regs.vh"
module rso_top_chk #(
  parameter [511:0] STRB_CYC = {16{32'd10}}
) (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pslverr,
  // measurement and memory
  input wire sample_done,
  input wire meas_arm,
  input wire mem_req,
  input wire [23:0] mem_addr,
  input wire [31:0] mem_data,
  input wire mem_ack,
  // output buffer and strobes
  input wire ob_valid,
  input wire [7:0] ob_data,
  input wire ob_eoi,
  input wire out_busy,
  input wire reading_done_strobe_n,
  input wire [7:0] backplane_trigger_line_o,
  input wire [7:0] backplane_trigger_line_oe_n
);
  reg [31:0] low_q;
  reg [31:0] low_d;
  wire wr_acc;
  assign wr_acc = psel & penable & pwrite;
  // counts low cycles since the last sample pulse
  always @* begin
    low_d = low_q;
    if (sample_done)
      low_d = 32'h0;
    else if (!reading_done_strobe_n)
      low_d = low_q + 32'h1;
  end
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      low_q <= 32'h0;
    else
      low_q <= low_d;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  a_strobe_fires: assert property (
    sample_done |=> ##[0:1] !reading_done_strobe_n)
    else $error("strobe missing after sample");
  a_strobe_length: assert property (
    $rose(reading_done_strobe_n) |-> low_q == STRB_CYC[31:0])
    else $error("strobe low time wrong");
  a_line_needs_strobe: assert property (
    backplane_trigger_line_oe_n != 8'hff |-> !reading_done_strobe_n)
    else $error("line pulled without strobe");
  a_line_pulls_low: assert property (
    backplane_trigger_line_o == 8'h00)
    else $error("line driven high");
  a_routes_off_reset: assert property (
    $fell(sys_rst) |-> backplane_trigger_line_oe_n == 8'hff)
    else $error("line driven after reset");
  a_base_reset: assert property (
    $fell(sys_rst) |-> mem_addr == 24'h200000)
    else $error("base not at reset value");
  a_mem_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
    $stable(mem_data))
    else $error("memory write dropped early");
  a_addr_step: assert property (
    mem_req && mem_ack |=> mem_addr == $past(mem_addr) + 24'h4)
    else $error("store address not stepped by four");
  a_eoi_on_lf: assert property (
    ob_valid && ob_eoi |-> ob_data == 8'h0a)
    else $error("end flag on wrong byte");
  a_busy_holds: assert property (
    out_busy |-> ob_valid)
    else $error("busy with empty buffer");
  a_bad_base: assert property (
    wr_acc && paddr == `RSO_OFF_BASE && pwdata < 32'h200000 |-> pslverr)
    else $error("low base accepted");
  a_start_arms: assert property (
    wr_acc && paddr == `RSO_OFF_CTRL && pwdata[0] |-> ##[1:2] meas_arm)
    else $error("start did not arm");
endmodule
bind rso_top rso_top_chk #(.STRB_CYC(STRB_CYC)) u_chk (.clock(clock),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .sample_done(sample_done), .meas_arm(meas_arm), .mem_req(mem_req),
  .mem_addr(mem_addr), .mem_data(mem_data), .mem_ack(mem_ack),
  .ob_valid(ob_valid), .ob_data(ob_data), .ob_eoi(ob_eoi),
  .out_busy(out_busy), .reading_done_strobe_n(reading_done_strobe_n),
  .backplane_trigger_line_o(backplane_trigger_line_o),
  .backplane_trigger_line_oe_n(backplane_trigger_line_oe_n));

// file: sim/rso_top_tb_top.sv
// Purpose: directed bench for rso_top
// Assumes: short strobe table, apb master tasks
// Notes: backplane lines resolved with pull-ups
`timescale 1ns/1ps
`include "rso_regs.vh"
module rso_top_tb_top;
  logic clock, sys_rst, psel, penable, pwrite, sample_done;
  logic rd_valid, rd_short, autozero, stall, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, rd_word, rd;
  logic [2:0] aperture_sel;
  logic [3:0] ack_dly;
  wire [31:0] prdata;
  wire [23:0] mem_addr;
  wire [31:0] mem_data;
  wire [7:0] ob_data, line_o, line_oe_n, trig_line;
  wire pready, pslverr, rd_ready, meas_arm, mem_req, mem_ack, ob_valid;
  wire ob_eoi, ob_ready, out_busy, strobe_n;
  int miscompares, checks_done, i, n;
  logic [7:0] ra [6] = '{`RSO_OFF_BASE, `RSO_OFF_SIZE, `RSO_OFF_STORE,
    `RSO_OFF_ROUTE, `RSO_OFF_BMIN, `RSO_OFF_BMAX};
  logic [31:0] rx [6] = '{32'h200000, 32'h0, 32'h0, 32'h0, 32'h200000,
    32'hdffffc};
  assign trig_line = line_oe_n | line_o;
  rso_top #(.STRB_CYC({16{32'd10}})) DUT (.clock(clock), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_done(sample_done), .aperture_sel(aperture_sel),
    .autozero(autozero), .rd_valid(rd_valid), .rd_word(rd_word),
    .rd_short(rd_short), .rd_ready(rd_ready), .meas_arm(meas_arm),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_data(mem_data),
    .mem_ack(mem_ack), .ob_valid(ob_valid), .ob_data(ob_data),
    .ob_eoi(ob_eoi), .ob_ready(ob_ready), .out_busy(out_busy),
    .reading_done_strobe_n(strobe_n), .backplane_trigger_line_o(line_o),
    .backplane_trigger_line_oe_n(line_oe_n));
  rso_far far (.clock(clock), .sys_rst(sys_rst), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_data(mem_data), .mem_ack(mem_ack),
    .ob_valid(ob_valid), .ob_data(ob_data), .ob_eoi(ob_eoi),
    .ob_ready(ob_ready), .ack_dly(ack_dly), .stall(stall));
  ////////////////////////////////////////////////////////////
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task push(input logic [31:0] w);
    @(posedge clock);
    rd_valid <= 1'b1;
    rd_word <= w;
    do @(posedge clock); while (rd_ready !== 1'b1);
    rd_valid <= 1'b0;
  endtask
  task fire;
    @(posedge clock);
    sample_done <= 1'b1;
    @(posedge clock);
    sample_done <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'ha) ? 8'h30 + v : 8'h57 + v;
  endfunction
  // compares one formatted reading popped from the host log
  task text(input logic [31:0] w, input logic last);
    for (int j = 0; j < 8; j++)
      chk(far.ob_q.pop_front(), {1'b0, hx(w[31 - 4 * j -: 4])});
    chk(far.ob_q.pop_front(), last ? 9'h10a : 9'h02c);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial begin
    #200000;
    miscompares++;
    give_verdict;
  end
  initial begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
    {sample_done, rd_valid, rd_short, autozero, stall} = 5'h0;
    {aperture_sel, rd_word, ack_dly} = {3'h2, 32'h0, 4'h3};
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    for (i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rx[i]);
    end
    apb(1'b0, 8'h3c, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, `RSO_OFF_BASE, 32'h1ffffc);
    chk(er, 1'b1);
    apb(1'b1, `RSO_OFF_BASE, 32'he00000);
    chk(er, 1'b1);
    apb(1'b1, `RSO_OFF_BASE, 32'hdffffc);
    apb(1'b0, `RSO_OFF_BASE, 32'h0);
    chk(rd, 32'hdffffc);
    apb(1'b1, `RSO_OFF_SIZE, 32'hc00001);
    chk(er, 1'b1);
    apb(1'b1, `RSO_OFF_BASE, 32'h800000);
    apb(1'b1, `RSO_OFF_SIZE, 32'h8);
    apb(1'b1, `RSO_OFF_STORE, 32'h1);
    apb(1'b0, `RSO_OFF_STORE, 32'h0);
    chk(rd, 32'h1);
    for (i = 0; i < 3; i++)
      push(32'h3f800000 + i);
    repeat (60) @(posedge clock);
    chk(far.wa.size(), 2);
    chk(far.wa[0], 24'h800000);
    chk(far.wa[1], 24'h800004);
    chk(far.wd[1], 32'h3f800001);
    apb(1'b0, `RSO_OFF_STAT, 32'h0);
    chk(rd, 32'h00000005);
    apb(1'b0, `RSO_OFF_NEXT, 32'h0);
    chk(rd, 32'h00800008);
    apb(1'b1, `RSO_OFF_STORE, 32'h0);
    apb(1'b1, `RSO_OFF_ROUTE, 32'h80);
    fire;
    chk({strobe_n, trig_line}, 9'h07f);
    repeat (20) @(posedge clock);
    chk(trig_line, 8'hff);
    apb(1'b1, `RSO_OFF_ROUTE, 32'h0);
    fire;
    chk({strobe_n, trig_line}, 9'h0ff);
    ack_dly <= 4'h0;
    apb(1'b1, `RSO_OFF_COUNT, 32'h2);
    apb(1'b1, `RSO_OFF_CTRL, 32'h1);
    push(32'h3f800000);
    push(32'hc0000000);
    for (n = 0; n < 500 && far.ob_q.size() < 18; n++) @(posedge clock);
    text(32'h3f800000, 1'b0);
    text(32'hc0000000, 1'b1);
    chk(far.wa.size(), 2);
    stall <= 1'b1;
    apb(1'b1, `RSO_OFF_COUNT, 32'h0);
    apb(1'b1, `RSO_OFF_CTRL, 32'h1);
    for (i = 0; i < 15; i++)
      push(32'h40000000);
    for (n = 0; n < 500 && out_busy !== 1'b1; n++) @(posedge clock);
    chk(out_busy, 1'b1);
    stall <= 1'b0;
    apb(1'b1, `RSO_OFF_CTRL, 32'h2);
    for (n = 0; n < 500 && out_busy !== 1'b0; n++) @(posedge clock);
    chk(out_busy, 1'b0);
    give_verdict;
  end
endmodule
